// file: hw/usab_defs.svh
// Purpose: Offsets, field positions, reset values and counts for the UART status block
// Assumes: Included by its bare name from the design file
// Notes:   Definitions only, no logic
`ifndef USAB_DEFS_SVH
`define USAB_DEFS_SVH

// Register offsets on the 3-bit host port
`define USAB_OFF_DATA     3'h0
`define USAB_OFF_LINE     3'h5
`define USAB_OFF_MODEM    3'h6
`define USAB_OFF_SCRATCH  3'h7

// Line status bit positions
`define USAB_LS_READY     0
`define USAB_LS_OVERRUN   1
`define USAB_LS_PARITY    2
`define USAB_LS_FRAME     3
`define USAB_LS_BREAK     4
`define USAB_LS_HOLD      5
`define USAB_LS_ALL_EMPTY 6
`define USAB_LS_FIFO_ERR  7

// Modem status: ring delta only flags a trailing edge
`define USAB_MS_RING      2

// Receive trigger levels, selected by two bits
`define USAB_TRIG_LVL0    1
`define USAB_TRIG_LVL1    4
`define USAB_TRIG_LVL2    8
`define USAB_TRIG_LVL3    14

// Break detection: start plus first stop, then two frames plus extra bits
`define USAB_FRAME_FIXED  2
`define USAB_BRK_EXTRA    3

// Reset value of byte registers
`define USAB_RST_BYTE     8'h00

`endif

// file: hw/usab_pkg.sv
// Purpose: Shared types of the UART status block
// Assumes: Compiled before the design module
// Notes:   Bit order of the structs matches the register layout
package usab_pkg;

    // One receive queue entry: error tags travel with the character
    typedef struct packed {
        logic       brk;
        logic       frm;
        logic       par;
        logic [7:0] data;
    } usab_rx_entry_s;

    // Modem line states in modem status order, bit 3 down to bit 0
    typedef struct packed {
        logic carrier;
        logic ring;
        logic set_ready;
        logic clear_send;
    } usab_modem_s;

endpackage : usab_pkg

// file: hw/usab_status_buffers.sv
// Purpose: Host status, data and scratch registers of a 16550-style serial port
// Assumes: 25 MHz clk_in, synchronous active-high reset, external shifter and baud logic
// Notes:   Read data appear one cycle after the read strobe, zero otherwise
// Function
// - FIFO error bit set while errored entries are queued, then held until a line status read
// - All-empty only when holding and shifter empty
// - Hold-empty sets on move, clears on write
// - FIFO mode: hold-empty equals transmit FIFO empty
// - Hold-empty with enable raises interrupt
// - Break after two frames plus three bits
// - Framing error from stop bit sampled space
// - FIFO errors shown when character reaches head
// - Parity error per even, odd, stick setting
// - Overrun when unread character gets overwritten
// - FIFO overrun only when full and more
// - Data ready set on load, cleared by read
// - FIFO mode: ready at or above trigger
// - Modem states high nibble, deltas low nibble
// - Any modem delta raises modem interrupt
// - Modem states follow input lines normally
// - Loopback mirrors modem control bits into states
// - Ring delta only on falling edge
// - Other deltas on any change
// - Offset zero read returns receive buffer
// - Offset zero write loads transmit holding
// - Scratch pad stores and returns host byte
// - Loopback returns transmitted characters to receiver
//
// Implementation choice: strobed register access.
`include "usab_defs.svh"

module usab_status_buffers
    import usab_pkg::*;
#(
    parameter int DEPTH = 16                      // Queue depth, a power of two
) (
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    input  wire logic [2:0] reg_addr_in,          // Register offset
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,            // One-cycle write strobe
    input  wire logic       reg_rd_in,            // One-cycle read strobe
    output wire logic [7:0] reg_rdata_out,
    input  wire logic       divisor_access_sel_in,
    input  wire logic       fifo_mode_in,
    input  wire logic [1:0] rx_trigger_sel_in,
    input  wire logic [1:0] word_len_sel_in,
    input  wire logic       parity_en_in,
    input  wire logic       parity_even_in,
    input  wire logic       parity_stick_in,
    input  wire logic       hold_empty_int_en_in,
    input  wire logic       loopback_sel_in,
    input  wire logic       term_ready_in,        // Modem control bit 0
    input  wire logic       req_send_in,          // Modem control bit 1
    input  wire logic       aux_out_one_in,
    input  wire logic       aux_out_two_in,
    input  wire logic       carrier_detect_in,
    input  wire logic       ring_indicate_in,
    input  wire logic       set_ready_in,
    input  wire logic       clear_send_in,
    input  wire logic       rx_char_valid_in,     // Pulse: character fully received
    input  wire logic [7:0] rx_char_in,
    input  wire logic       rx_parity_bit_in,
    input  wire logic       rx_stop_bit_in,       // First stop bit as sampled
    input  wire logic       rx_serial_in,         // Serial input level
    input  wire logic       rx_bit_tick_in,       // One pulse per bit time
    input  wire logic       tx_take_in,           // Shifter accepts tx_char_out
    input  wire logic       tx_busy_in,           // Shifter still sending
    output wire logic       tx_valid_out,
    output wire logic [7:0] tx_char_out,
    output wire logic       hold_empty_irq_out,
    output wire logic       modem_irq_out
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    // Storage and state
    usab_rx_entry_s rx_mem [DEPTH];               // Receive queue with error tags
    logic [7:0]     tx_mem [DEPTH];               // Transmit queue
    logic [AW-1:0]  rx_wr_reg, rx_rd_reg;
    logic [AW-1:0]  tx_wr_reg, tx_rd_reg;
    logic [CW-1:0]  rx_cnt_reg, tx_cnt_reg;
    logic [CW-1:0]  err_cnt_reg;                  // Queued entries with any error
    logic [7:0]     tx_char_reg;                  // Stage facing the shifter
    logic           tx_valid_reg;
    logic           ovr_reg, par_reg, frm_reg, brk_reg, fifo_err_reg;
    logic [5:0]     brk_cnt_reg;                  // Space bit times seen
    usab_modem_s    modem_prev_reg;
    logic           modem_armed_reg;              // No delta on first cycle out of reset
    logic [3:0]     delta_reg;
    logic [7:0]     scratch_reg;
    logic [7:0]     rdata_reg;
    logic           hold_irq_reg, modem_irq_reg;

    // Host decode; buffers only reachable with divisor access clear
    wire logic data_sel   = (reg_addr_in == `USAB_OFF_DATA) && !divisor_access_sel_in;
    wire logic host_rx_rd = reg_rd_in && data_sel;
    wire logic host_tx_wr = reg_wr_in && data_sel;
    wire logic line_rd    = reg_rd_in && (reg_addr_in == `USAB_OFF_LINE);
    wire logic modem_rd   = reg_rd_in && (reg_addr_in == `USAB_OFF_MODEM);
    wire logic scratch_wr = reg_wr_in && (reg_addr_in == `USAB_OFF_SCRATCH);

    // Word length: unused upper data bits are masked off
    wire logic [3:0] data_bits = 4'(5) + {2'b00, word_len_sel_in};
    wire logic [7:0] data_mask = 8'hFF >> (4'h8 - data_bits);
    wire logic [7:0] rx_masked = rx_char_in & data_mask;

    // Expected parity bit: stick forces a constant, else even or odd count
    wire logic par_expect = parity_stick_in ? !parity_even_in
                          : (parity_even_in ? ^rx_masked : ~^rx_masked);
    wire logic par_bad    = parity_en_in && (rx_parity_bit_in != par_expect);

    // Break: limit is two whole frames plus extra bits, flagged once per run
    wire logic [5:0] frame_bits = 6'(`USAB_FRAME_FIXED) + {2'b00, data_bits}
                                + {5'h00, parity_en_in};
    wire logic [5:0] brk_limit  = {frame_bits[4:0], 1'b0} + 6'(`USAB_BRK_EXTRA);
    wire logic line_mark  = loopback_sel_in || rx_serial_in;       // Loopback idles the line
    wire logic brk_event  = rx_bit_tick_in && !line_mark && (brk_cnt_reg == brk_limit);
    wire logic brk_grow   = rx_bit_tick_in && !line_mark && (brk_cnt_reg <= brk_limit);
    wire logic [5:0] brk_cnt_next = (rx_bit_tick_in && line_mark) ? 6'h00
                                  : brk_grow ? brk_cnt_reg + 6'h01 : brk_cnt_reg;

    // Receive source: break char, looped transmit char, or external character
    wire logic lb_push  = loopback_sel_in && tx_valid_reg;
    wire logic ext_push = !loopback_sel_in && rx_char_valid_in;
    wire logic rx_push  = brk_event || lb_push || ext_push;
    usab_rx_entry_s rx_entry;
    assign rx_entry = brk_event ? {3'b100, 8'h00}
                    : lb_push   ? {3'b000, tx_char_reg & data_mask}
                    : {1'b0, !rx_stop_bit_in, par_bad, rx_masked};

    // Receive queue control; outside FIFO mode the queue holds one character
    wire logic rx_empty   = (rx_cnt_reg == '0);
    wire logic rx_full    = fifo_mode_in ? (rx_cnt_reg == CW'(DEPTH)) : !rx_empty;
    wire logic rx_pop     = host_rx_rd && !rx_empty;
    wire logic rx_store   = rx_push && (!rx_full || rx_pop);
    wire logic rx_over    = rx_push && rx_full && !rx_pop;
    wire logic rx_clobber = rx_over && !fifo_mode_in;  // Single buffer keeps newest char
    usab_rx_entry_s rx_head, rx_after;
    assign rx_head  = rx_mem[rx_rd_reg];
    assign rx_after = rx_mem[rx_rd_reg + AW'(1)];

    // Error tags reach line status only when their character becomes the head
    wire logic head_from_in  = rx_clobber || (rx_store && (rx_empty
                             || (rx_pop && rx_cnt_reg == CW'(1))));
    wire logic head_from_mem = rx_pop && (rx_cnt_reg > CW'(1));
    wire logic [2:0] head_err = head_from_in  ? {rx_entry.brk, rx_entry.frm, rx_entry.par}
                              : head_from_mem ? {rx_after.brk, rx_after.frm, rx_after.par}
                              : 3'b000;

    // Count of errored entries for the FIFO error bit
    wire logic err_inc = (rx_store || rx_clobber) && (|{rx_entry.brk, rx_entry.frm, rx_entry.par});
    wire logic err_dec = (rx_pop || rx_clobber) && (|{rx_head.brk, rx_head.frm, rx_head.par});

    // Sticky flags: a new event wins over a clearing read in the same cycle
    wire logic ovr_next = rx_over     || (ovr_reg && !line_rd);
    wire logic par_next = head_err[0] || (par_reg && !line_rd);
    wire logic frm_next = head_err[1] || (frm_reg && !line_rd);
    wire logic brk_next = head_err[2] || (brk_reg && !line_rd);
    wire logic fifo_err_next = fifo_mode_in
                             && ((err_cnt_reg != '0) || (fifo_err_reg && !line_rd));

    // Data ready: level from queue fill, so it clears when reads take the fill below the trigger in FIFO mode, or to empty outside it
    wire logic [CW-1:0] trig_level =
        (rx_trigger_sel_in == 2'b00) ? CW'(`USAB_TRIG_LVL0) :
        (rx_trigger_sel_in == 2'b01) ? CW'(`USAB_TRIG_LVL1) :
        (rx_trigger_sel_in == 2'b10) ? CW'(`USAB_TRIG_LVL2) : CW'(`USAB_TRIG_LVL3);
    wire logic rx_ready = fifo_mode_in ? (rx_cnt_reg >= trig_level)
                                       : !rx_empty;

    // Transmit queue; a write into a full queue is dropped
    wire logic tx_empty  = (tx_cnt_reg == '0);
    wire logic tx_full   = fifo_mode_in ? (tx_cnt_reg == CW'(DEPTH)) : !tx_empty;
    wire logic tx_store  = host_tx_wr && !tx_full;
    wire logic tx_take   = loopback_sel_in || tx_take_in;   // Loopback drains the stage itself
    wire logic tx_move   = !tx_empty && (!tx_valid_reg || tx_take);
    wire logic tx_valid_next = tx_move || (tx_valid_reg && !tx_take);
    wire logic tx_hold_empty = tx_empty;
    wire logic tx_all_empty  = tx_empty && !tx_valid_reg && !tx_busy_in;

    // Modem states: loopback feeds back the modem control bits
    usab_modem_s modem_now;
    assign modem_now = loopback_sel_in
        ? {aux_out_two_in, aux_out_one_in, term_ready_in, req_send_in}
        : {carrier_detect_in, ring_indicate_in, set_ready_in, clear_send_in};

    // Delta bits, one per modem line
    logic [3:0] delta_set;
    logic [3:0] delta_next;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_delta
            if (gi == `USAB_MS_RING) begin : g_trail
                // Ring only reports the falling edge
                assign delta_set[gi] = modem_armed_reg && modem_prev_reg[gi]
                                     && !modem_now[gi];
            end else begin : g_any
                // Others report either direction
                assign delta_set[gi] = modem_armed_reg
                                     && (modem_prev_reg[gi] != modem_now[gi]);
            end
            // Read clears, but a change in the read cycle survives
            assign delta_next[gi] = delta_set[gi] || (delta_reg[gi] && !modem_rd);
        end
    endgenerate

    // Register views
    logic [7:0] line_val;
    assign line_val[`USAB_LS_READY]     = rx_ready;
    assign line_val[`USAB_LS_OVERRUN]   = ovr_reg;
    assign line_val[`USAB_LS_PARITY]    = par_reg;
    assign line_val[`USAB_LS_FRAME]     = frm_reg;
    assign line_val[`USAB_LS_BREAK]     = brk_reg;
    assign line_val[`USAB_LS_HOLD]      = tx_hold_empty;
    assign line_val[`USAB_LS_ALL_EMPTY] = tx_all_empty;
    assign line_val[`USAB_LS_FIFO_ERR]  = fifo_err_reg;
    wire logic [7:0] modem_val = {modem_now, delta_reg};

    // Read mux; unmapped offsets and divisor reads answer zero here
    wire logic [7:0] rdata_mux =
        (reg_addr_in == `USAB_OFF_DATA)    ? (divisor_access_sel_in ? 8'h00
                                                                    : rx_head.data) :
        (reg_addr_in == `USAB_OFF_LINE)    ? line_val :
        (reg_addr_in == `USAB_OFF_MODEM)   ? modem_val :
        (reg_addr_in == `USAB_OFF_SCRATCH) ? scratch_reg : 8'h00;

    // Queue storage, not reset: contents only matter behind the counters
    always_ff @(posedge clk_in) begin
        if (rx_store) begin
            rx_mem[rx_wr_reg] <= rx_entry;
        end else if (rx_clobber) begin
            rx_mem[rx_rd_reg] <= rx_entry;
        end
        if (tx_store) begin
            tx_mem[tx_wr_reg] <= reg_wdata_in;
        end
    end

    // Receive pointers and counts
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rx_wr_reg   <= '0;
            rx_rd_reg   <= '0;
            rx_cnt_reg  <= '0;
            err_cnt_reg <= '0;
        end else begin
            rx_wr_reg   <= rx_wr_reg + AW'(rx_store);
            rx_rd_reg   <= rx_rd_reg + AW'(rx_pop);
            rx_cnt_reg  <= rx_cnt_reg + CW'(rx_store) - CW'(rx_pop);
            err_cnt_reg <= err_cnt_reg + CW'(err_inc) - CW'(err_dec);
        end
    end

    // Transmit pointers, count and output stage
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            tx_wr_reg    <= '0;
            tx_rd_reg    <= '0;
            tx_cnt_reg   <= '0;
            tx_valid_reg <= 1'b0;
            tx_char_reg  <= `USAB_RST_BYTE;
        end else begin
            tx_wr_reg    <= tx_wr_reg + AW'(tx_store);
            tx_rd_reg    <= tx_rd_reg + AW'(tx_move);
            tx_cnt_reg   <= tx_cnt_reg + CW'(tx_store) - CW'(tx_move);
            tx_valid_reg <= tx_valid_next;
            if (tx_move) begin
                tx_char_reg <= tx_mem[tx_rd_reg];    // Bit 0 leaves first
            end
        end
    end

    // Line status flags and break counter
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ovr_reg      <= 1'b0;
            par_reg      <= 1'b0;
            frm_reg      <= 1'b0;
            brk_reg      <= 1'b0;
            fifo_err_reg <= 1'b0;
            brk_cnt_reg  <= 6'h00;
        end else begin
            ovr_reg      <= ovr_next;
            par_reg      <= par_next;
            frm_reg      <= frm_next;
            brk_reg      <= brk_next;
            fifo_err_reg <= fifo_err_next;
            brk_cnt_reg  <= brk_cnt_next;
        end
    end

    // Modem status tracking
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            modem_prev_reg  <= '0;
            modem_armed_reg <= 1'b0;
            delta_reg       <= 4'h0;
        end else begin
            modem_prev_reg  <= modem_now;
            modem_armed_reg <= 1'b1;
            delta_reg       <= delta_next;
        end
    end

    // Scratch pad, read data and interrupt outputs
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            scratch_reg   <= `USAB_RST_BYTE;
            rdata_reg     <= 8'h00;
            hold_irq_reg  <= 1'b0;
            modem_irq_reg <= 1'b0;
        end else begin
            if (scratch_wr) begin
                scratch_reg <= reg_wdata_in;
            end
            rdata_reg     <= reg_rd_in ? rdata_mux : 8'h00;
            hold_irq_reg  <= tx_hold_empty && hold_empty_int_en_in;
            modem_irq_reg <= |delta_next;
        end
    end

    assign reg_rdata_out      = rdata_reg;
    assign tx_valid_out       = tx_valid_reg;
    assign tx_char_out        = tx_char_reg;
    assign hold_empty_irq_out = hold_irq_reg;
    assign modem_irq_out      = modem_irq_reg;

    // Checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    sequence s_tx_write;
        host_tx_wr && !tx_full;
    endsequence
    sequence s_ring_fall;
        modem_now.ring ##1 !modem_now.ring;
    endsequence
    sequence s_scratch_echo;
        scratch_wr ##1 !scratch_wr ##1 (reg_rd_in && reg_addr_in == `USAB_OFF_SCRATCH);
    endsequence

    a_fifo_err_off: assert property (!fifo_mode_in |=> !line_val[`USAB_LS_FIFO_ERR])
        else $error("FIFO error bit set outside FIFO mode");
    a_all_empty_busy: assert property (tx_valid_out |-> !line_val[`USAB_LS_ALL_EMPTY])
        else $error("All-empty set while a character waits");
    a_write_clears_hold: assert property (s_tx_write |=> !line_val[`USAB_LS_HOLD])
        else $error("Hold-empty still set after a write");
    a_hold_irq_follow: assert property (tx_empty && hold_empty_int_en_in
                                        |=> hold_empty_irq_out)
        else $error("No interrupt for empty holding buffer");
    a_overrun_sets: assert property (rx_push && rx_full && !rx_pop
                                     |=> line_val[`USAB_LS_OVERRUN])
        else $error("Overrun not flagged");
    a_overrun_read_kept: assert property (rx_over && line_rd
                                          |=> line_val[`USAB_LS_OVERRUN])
        else $error("Overrun lost in clearing read");
    a_ring_trailing: assert property (s_ring_fall |=> delta_reg[`USAB_MS_RING])
        else $error("Ring trailing edge not flagged");
    a_modem_irq_any: assert property (|delta_reg |-> modem_irq_out)
        else $error("Modem interrupt missing while delta set");
    a_loop_mirror: assert property (loopback_sel_in |-> modem_val[7:4] ==
        {aux_out_two_in, aux_out_one_in, term_ready_in, req_send_in})
        else $error("Loopback modem states wrong");
    a_scratch_echo: assert property (s_scratch_echo |=>
                                     reg_rdata_out == $past(reg_wdata_in, 3))
        else $error("Scratch pad read differs from write");
    a_pop_once: assert property (rx_pop && !rx_store
                                 |=> rx_cnt_reg == $past(rx_cnt_reg) - CW'(1))
        else $error("Receive read did not pop exactly once");

endmodule : usab_status_buffers

// file: verification/usab_host_model.sv
// Purpose: Host processor side of the register port
// Assumes: Strobes change right after a rising edge
// Notes:   Read data are taken in the cycle after the strobe, never later
module usab_host_model (
    input  wire logic       clk_in,
    input  wire logic [7:0] rdata_in,
    output logic      [2:0] addr_out,
    output logic      [7:0] wdata_out,
    output logic            wr_out,
    output logic            rd_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus from time zero
    initial begin
        addr_out  = 3'h0;
        wdata_out = 8'h00;
        wr_out    = 1'b0;
        rd_out    = 1'b0;
    end

    // One-cycle write; offset 0 reaches the buffers only with divisor access clear
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_out  <= a;
        wdata_out <= d;
        wr_out    <= 1'b1;
        @(posedge clk_in);
        wr_out    <= 1'b0;
    endtask : wr

    // One-cycle read; the answer stands only in the following cycle
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out   <= 1'b1;
        @(posedge clk_in);
        rd_out   <= 1'b0;
        @(posedge clk_in);
        d = rdata_in;        // Still the answer: the register updates after this edge
    endtask : rd
endmodule : usab_host_model

// file: verification/tb.sv
// Purpose: Self-checking bench of the UART status block
// Assumes: 40 ns clock, reset held five cycles
// Notes:   Bench stands in for the shifter, modem lines and the serial break line
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_in = 1'b0, reset_in = 1'b1;
    logic [2:0] reg_addr_in;
    logic [7:0] reg_wdata_in, reg_rdata_out, rx_char_in, tx_char_out;
    logic       reg_wr_in, reg_rd_in, divisor_access_sel_in = 1'b0, fifo_mode_in = 1'b0;
    logic [1:0] rx_trigger_sel_in = 2'h1;  // Four bytes
    logic       parity_en_in = 1'b1, parity_even_in = 1'b1, hold_empty_int_en_in = 1'b1;
    logic       loopback_sel_in = 1'b0, term_ready_in = 1'b0, req_send_in = 1'b0;
    logic       aux_out_one_in = 1'b0, aux_out_two_in = 1'b0, carrier_detect_in = 1'b0;
    logic       ring_indicate_in = 1'b0, set_ready_in = 1'b0, rx_char_valid_in = 1'b0;
    logic       rx_parity_bit_in = 1'b0, rx_stop_bit_in = 1'b1, tx_take_in = 1'b0;
    logic       tx_busy_in = 1'b0, tx_valid_out, hold_empty_irq_out, modem_irq_out;
    logic       rx_serial_in = 1'b1, rx_bit_tick_in = 1'b0;
    int         failures = 0, checked = 0;

    // Free-running clock
    always #20 clk_in = ~clk_in;

    usab_status_buffers #(.DEPTH(16)) i_usab_status_buffers (
        .clk_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
        .divisor_access_sel_in, .fifo_mode_in, .rx_trigger_sel_in, .word_len_sel_in(2'h3),
        .parity_en_in, .parity_even_in, .parity_stick_in(1'b0), .hold_empty_int_en_in,
        .loopback_sel_in, .term_ready_in, .req_send_in, .aux_out_one_in, .aux_out_two_in,
        .carrier_detect_in, .ring_indicate_in, .set_ready_in, .clear_send_in(1'b0),
        .rx_char_valid_in, .rx_char_in, .rx_parity_bit_in, .rx_stop_bit_in,
        .rx_serial_in, .rx_bit_tick_in, .tx_take_in, .tx_busy_in, .tx_valid_out,
        .tx_char_out, .hold_empty_irq_out, .modem_irq_out);
    usab_host_model u_host (.clk_in, .rdata_in(reg_rdata_out), .addr_out(reg_addr_in),
        .wdata_out(reg_wdata_in), .wr_out(reg_wr_in), .rd_out(reg_rd_in));

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // Register read compared against an expected byte
    task automatic rchk(input logic [2:0] a, input logic [7:0] e, input string n);
        logic [7:0] d;
        u_host.rd(a, d);
        chk(n, e, d);
    endtask : rchk

    // One character from the absent receive shifter
    task automatic push(input logic [7:0] d, input logic p, input logic s);
        @(posedge clk_in);
        rx_char_valid_in <= 1'b1;
        rx_char_in       <= d;
        rx_parity_bit_in <= p;
        rx_stop_bit_in   <= s;
        @(posedge clk_in);
        rx_char_valid_in <= 1'b0;
    endtask : push

    // Shifter takes the waiting character; b is its busy level afterwards
    task automatic take(input logic b);
        @(posedge clk_in);
        tx_take_in <= 1'b1;
        tx_busy_in <= b;
        @(posedge clk_in);
        tx_take_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1;
    endtask : take

    task automatic t_reset();
        rchk(3'h5, 8'h60, "line_status");
        u_host.wr(3'h7, 8'hC3);
        rchk(3'h7, 8'hC3, "scratch_pad");
        rchk(3'h2, 8'h00, "unmapped");
        $display("t_reset done");
    endtask : t_reset

    // Second write waits behind a stalled shifter
    task automatic t_tx();
        u_host.wr(3'h0, 8'hA5);
        u_host.wr(3'h0, 8'h3C);
        repeat (2) @(posedge clk_in);
        #1 chk("tx_char_out", 8'hA5, tx_char_out);
        chk("tx_valid_out", 8'h01, {7'h00, tx_valid_out});
        rchk(3'h5, 8'h00, "line_status");
        chk("hold_empty_irq_out", 8'h00, {7'h00, hold_empty_irq_out});
        take(1'b1);
        chk("tx_char_out", 8'h3C, tx_char_out);
        rchk(3'h5, 8'h20, "line_status");
        chk("hold_empty_irq_out", 8'h01, {7'h00, hold_empty_irq_out});
        take(1'b0);
        chk("tx_valid_out", 8'h00, {7'h00, tx_valid_out});
        rchk(3'h5, 8'h60, "line_status");
        $display("t_tx done");
    endtask : t_tx

    // Even parity, single-character buffer
    task automatic t_rx();
        push(8'h81, 1'b0, 1'b1);
        rchk(3'h5, 8'h61, "line_status");
        rchk(3'h0, 8'h81, "receive_buffer");
        rchk(3'h5, 8'h60, "line_status");
        push(8'h81, 1'b1, 1'b1);
        rchk(3'h5, 8'h65, "line_status");
        rchk(3'h5, 8'h61, "line_status");
        rchk(3'h0, 8'h81, "receive_buffer");
        push(8'h7E, 1'b0, 1'b0);
        rchk(3'h5, 8'h69, "line_status");
        rchk(3'h0, 8'h7E, "receive_buffer");
        push(8'h11, 1'b0, 1'b1);
        push(8'h22, 1'b0, 1'b1);
        rchk(3'h5, 8'h63, "line_status");
        rchk(3'h0, 8'h22, "receive_buffer");
        $display("t_rx done");
    endtask : t_rx

    // Ready only at the trigger level of four
    task automatic t_fifo();
        @(posedge clk_in);
        fifo_mode_in <= 1'b1;
        for (int i = 0; i < 3; i++) push(8'(i * 3), 1'b0, 1'b1);
        rchk(3'h5, 8'h60, "line_status");
        push(8'h09, 1'b0, 1'b1);
        rchk(3'h5, 8'h61, "line_status");
        for (int i = 0; i < 4; i++) rchk(3'h0, 8'(i * 3), "receive_buffer");
        fifo_mode_in <= 1'b0;
        $display("t_fifo done");
    endtask : t_fifo

    // Space on the line: 8 data bits and parity make 11-bit frames, so 2 * 11 + 3 = 25
    // bit times are tolerated and the 26th tick queues the break character
    task automatic t_break();
        rx_serial_in <= 1'b0;
        for (int i = 0; i < 26; i++) begin
            rx_bit_tick_in <= 1'b1;
            @(posedge clk_in);
            rx_bit_tick_in <= 1'b0;
            @(posedge clk_in);
            if (i == 24) rchk(3'h5, 8'h60, "line_status");
        end
        rchk(3'h5, 8'h71, "line_status");
        rchk(3'h0, 8'h00, "receive_buffer");
        rx_serial_in <= 1'b1;
        $display("t_break done");
    endtask : t_break

    task automatic t_modem();
        @(posedge clk_in);
        carrier_detect_in <= 1'b1;
        ring_indicate_in  <= 1'b1;
        repeat (2) @(posedge clk_in);
        #1 chk("modem_irq_out", 8'h01, {7'h00, modem_irq_out});
        rchk(3'h6, 8'hC8, "modem_line_status");
        rchk(3'h6, 8'hC0, "modem_line_status");
        @(posedge clk_in);
        ring_indicate_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rchk(3'h6, 8'h84, "modem_line_status");
        loopback_sel_in   <= 1'b1;
        term_ready_in     <= 1'b1;
        carrier_detect_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rchk(3'h6, 8'h2A, "modem_line_status");
        u_host.wr(3'h0, 8'h5A);
        repeat (3) @(posedge clk_in);
        rchk(3'h0, 8'h5A, "receive_buffer");
        $display("t_modem done");
    endtask : t_modem

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    // Main sequence
    initial begin
        rx_char_in = 8'h00;
        repeat (5) @(posedge clk_in);
        reset_in <= 1'b0;
        t_reset();
        t_tx();
        t_rx();
        t_fifo();
        t_break();
        t_modem();
        final_report();
    end

    // Watchdog, well beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clk_in);
        failures++;
        final_report();
    end
endmodule : tb
